//--- shared/gpio_pkg.sv
// Purpose: Constants and state layout for the general purpose I/O port
// Assumes: 8-bit port, one special input-only pin, byte-wide register port
// Notes:   Register offsets are the byte addresses on the register port
package gpio_pkg;

    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int ADDR_W  = 12;
    localparam int DATA_W  = 8;
    localparam int PIN_N   = 8;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [ADDR_W-1:0] OFS_INPUT_THRESHOLD = 12'hf08;
    localparam logic [ADDR_W-1:0] OFS_SLEW_LIMIT      = 12'hf09;
    localparam logic [ADDR_W-1:0] OFS_OPEN_DRAIN      = 12'hf0a;
    localparam logic [ADDR_W-1:0] OFS_PULL_UP         = 12'hf0b;
    localparam logic [ADDR_W-1:0] OFS_ANALOG_SELECT   = 12'hf0c;
    localparam logic [ADDR_W-1:0] OFS_SPECIAL_THRESH  = 12'hf25;
    localparam logic [ADDR_W-1:0] OFS_SPECIAL_PULL_UP = 12'hf28;
    localparam logic [ADDR_W-1:0] OFS_RISE_ENABLE     = 12'hf30;
    localparam logic [ADDR_W-1:0] OFS_FALL_ENABLE     = 12'hf31;
    localparam logic [ADDR_W-1:0] OFS_SPECIAL_EDGE    = 12'hf32;
    localparam logic [ADDR_W-1:0] OFS_OUTPUT_LATCH    = 12'hf82;
    localparam logic [ADDR_W-1:0] OFS_DIRECTION       = 12'hf87;
    localparam logic [ADDR_W-1:0] OFS_PIN_LEVEL       = 12'hf8c;
    localparam logic [ADDR_W-1:0] OFS_SPECIAL_PORT    = 12'hf90;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int SPECIAL_BIT   = 3;
    localparam int SP_RISE_BIT   = 0;
    localparam int SP_FALL_BIT   = 1;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [DATA_W-1:0] RST_ANALOG_SELECT = 8'hff;
    localparam logic [DATA_W-1:0] RST_DIRECTION     = 8'hff;
    localparam logic [DATA_W-1:0] RST_ZERO          = 8'h00;

    // ------------------------------------------------------------
    // Whole state of the port
    // ------------------------------------------------------------
    typedef struct packed {
        logic [DATA_W-1:0] output_latch;
        logic [DATA_W-1:0] direction;
        logic [DATA_W-1:0] analog_select;
        logic [DATA_W-1:0] open_drain;
        logic [DATA_W-1:0] slew_limit;
        logic [DATA_W-1:0] input_threshold;
        logic [DATA_W-1:0] pull_up;
        logic [DATA_W-1:0] rise_en;
        logic [DATA_W-1:0] fall_en;
        logic              sp_threshold;
        logic              sp_pull_up;
        logic              sp_rise_en;
        logic              sp_fall_en;
        logic [DATA_W-1:0] st_s1;
        logic [DATA_W-1:0] st_s2;
        logic [DATA_W-1:0] ttl_s1;
        logic [DATA_W-1:0] ttl_s2;
        logic [1:0]        sp_s1;
        logic [1:0]        sp_s2;
        logic [DATA_W-1:0] level_prev;
        logic              sp_prev;
        logic [DATA_W-1:0] pin_out;
        logic [DATA_W-1:0] pin_oe_n;
        logic [DATA_W-1:0] pull_up_on;
        logic [DATA_W-1:0] slew_on;
        logic              sp_pull_up_on;
        logic [DATA_W-1:0] change_evt;
        logic              sp_change_evt;
        logic [DATA_W-1:0] rdata;
    } port_state_t;

endpackage : gpio_pkg

//--- logic/general_purpose_io_port.sv
// Purpose: One 8-bit general purpose I/O port plus the special input pin
// Assumes: Pin levels arrive asynchronously; straps and peripheral
//          requests come from logic on clk
// Notes:   Pin drive, pull-up, slew and change-event outputs are registered, one cycle late
//
// How it works
// - After reset all pins undriven, direction all ones
// - Analog inputs enabled only by analog select
// - Analog select never touches digital output path
// - Analog output forces digital driver off
// - Priority: config, analog out, port
// - Direction one disables driver, zero drives latch or remap output
// - Pin level read returns pins, write latch
// - Pin level write puts the whole byte straight into latch
// - Latch holds last latch or pin-level write
// - Analog-selected pins always read zero
// - Analog select resets to analog mode
// - Open-drain bit stops driving high
// - I2C ownership forces open-drain behaviour
// - Slew-limit bit selects limited edge per pin
// - Threshold select governs reads and edge detect
// - Per-pin weak pull-up enable
// - Per-pin rising or falling change events
// - Special port exists only without reset pin
// - Special bit read-only, reads one if reset
// - Special pull-up forced on for reset, programming
// - Output latch read returns latch contents
// - Analog select disables digital input buffer
`timescale 1ns/1ps

module general_purpose_io_port
    import gpio_pkg::*;
(
    // Clock and reset
    input  wire logic                        clk,
    input  wire logic                        reset,
    // Register port
    input  wire logic [gpio_pkg::ADDR_W-1:0] addr,
    input  wire logic [gpio_pkg::DATA_W-1:0] wdata,
    input  wire logic                        wr,
    input  wire logic                        rd,
    output logic      [gpio_pkg::DATA_W-1:0] rdata,
    // Pin levels through both input thresholds
    input  wire logic [gpio_pkg::DATA_W-1:0] pin_st,
    input  wire logic [gpio_pkg::DATA_W-1:0] pin_ttl,
    input  wire logic                        special_pin_st,
    input  wire logic                        special_pin_ttl,
    // Pin drive
    output logic      [gpio_pkg::DATA_W-1:0] pin_out,
    output logic      [gpio_pkg::DATA_W-1:0] pin_oe_n,
    output logic      [gpio_pkg::DATA_W-1:0] pull_up_on,
    output logic      [gpio_pkg::DATA_W-1:0] slew_limit_on,
    output logic      [gpio_pkg::DATA_W-1:0] threshold_ttl,
    output logic                             special_pin_pull_up,
    output logic                             special_threshold_ttl,
    // Configuration straps
    input  wire logic                        external_reset_pin_enable,
    input  wire logic                        low_voltage_prog_enable,
    input  wire logic [gpio_pkg::DATA_W-1:0] config_own,
    input  wire logic [gpio_pkg::DATA_W-1:0] config_out,
    input  wire logic [gpio_pkg::DATA_W-1:0] config_oe,
    // Analog functions
    input  wire logic [gpio_pkg::DATA_W-1:0] analog_out_en,
    output logic      [gpio_pkg::DATA_W-1:0] analog_in_en,
    // Pin remap logic
    input  wire logic [gpio_pkg::DATA_W-1:0] remap_out_sel,
    input  wire logic [gpio_pkg::DATA_W-1:0] remap_out,
    input  wire logic [gpio_pkg::DATA_W-1:0] i2c_own,
    output logic      [gpio_pkg::DATA_W-1:0] digital_in,
    output logic                             special_digital_in,
    // Edge change hooks
    output logic      [gpio_pkg::DATA_W-1:0] change_evt,
    output logic                             special_change_evt
);
    import gpio_pkg::*;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    port_state_t       st_ff;
    port_state_t       nxt_st;
    logic [DATA_W-1:0] level_sel;
    logic [DATA_W-1:0] level_dig;
    logic [DATA_W-1:0] drv_val;
    logic [DATA_W-1:0] drv_oe_n;
    logic              sp_level;
    logic              sp_present;

    // ------------------------------------------------------------
    // Input and drive path per pin
    // ------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < PIN_N; g++)
        begin : g_pin
            logic val;
            logic od;
            logic en_n;
            assign level_sel[g] = st_ff.input_threshold[g] ? st_ff.ttl_s2[g]
                                                           : st_ff.st_s2[g];
            assign level_dig[g] = st_ff.analog_select[g] ? 1'b0 : level_sel[g];

            assign val = remap_out_sel[g] ? remap_out[g] : st_ff.output_latch[g];
            assign od  = st_ff.open_drain[g] | i2c_own[g];
            assign en_n = st_ff.direction[g] | (od & val);

            always_comb
            begin
                if (config_own[g])
                begin
                    drv_val[g]  = config_out[g];
                    drv_oe_n[g] = ~config_oe[g];
                end
                else if (analog_out_en[g])
                begin
                    drv_val[g]  = 1'b0;
                    drv_oe_n[g] = 1'b1;
                end
                else
                begin
                    drv_val[g]  = val;
                    drv_oe_n[g] = en_n;
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // Special pin
    // ------------------------------------------------------------
    // present only with reset pin off
    assign sp_present = ~external_reset_pin_enable;
    assign sp_level   = st_ff.sp_threshold ? st_ff.sp_s2[1] : st_ff.sp_s2[0];

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb
    begin
        nxt_st = st_ff;

        // Two-stage synchronisers; stage one feeds only stage two
        nxt_st.st_s1  = pin_st;
        nxt_st.st_s2  = st_ff.st_s1;
        nxt_st.ttl_s1 = pin_ttl;
        nxt_st.ttl_s2 = st_ff.ttl_s1;
        nxt_st.sp_s1  = {special_pin_ttl, special_pin_st};
        nxt_st.sp_s2  = st_ff.sp_s1;

        // Register writes
        if (wr)
        begin
            case (addr)
                OFS_OUTPUT_LATCH:    nxt_st.output_latch = wdata;
                OFS_PIN_LEVEL:       nxt_st.output_latch = wdata;
                OFS_DIRECTION:       nxt_st.direction = wdata;
                OFS_ANALOG_SELECT:   nxt_st.analog_select = wdata;
                OFS_OPEN_DRAIN:      nxt_st.open_drain = wdata;
                OFS_SLEW_LIMIT:      nxt_st.slew_limit = wdata;
                OFS_INPUT_THRESHOLD: nxt_st.input_threshold = wdata;
                OFS_PULL_UP:         nxt_st.pull_up = wdata;
                OFS_RISE_ENABLE:     nxt_st.rise_en = wdata;
                OFS_FALL_ENABLE:     nxt_st.fall_en = wdata;
                OFS_SPECIAL_THRESH:  nxt_st.sp_threshold = wdata[SPECIAL_BIT];
                OFS_SPECIAL_PULL_UP: nxt_st.sp_pull_up = wdata[SPECIAL_BIT];
                OFS_SPECIAL_EDGE:
                begin
                    nxt_st.sp_rise_en = wdata[SP_RISE_BIT];
                    nxt_st.sp_fall_en = wdata[SP_FALL_BIT];
                end
                default:             nxt_st.rdata = st_ff.rdata;
            endcase
        end

        // Read data valid only in the cycle after the strobe
        nxt_st.rdata = RST_ZERO;
        if (rd)
        begin
            case (addr)
                OFS_OUTPUT_LATCH:    nxt_st.rdata = st_ff.output_latch;
                OFS_PIN_LEVEL:       nxt_st.rdata = level_dig;
                OFS_DIRECTION:       nxt_st.rdata = st_ff.direction;
                OFS_ANALOG_SELECT:   nxt_st.rdata = st_ff.analog_select;
                OFS_OPEN_DRAIN:      nxt_st.rdata = st_ff.open_drain;
                OFS_SLEW_LIMIT:      nxt_st.rdata = st_ff.slew_limit;
                OFS_INPUT_THRESHOLD: nxt_st.rdata = st_ff.input_threshold;
                OFS_PULL_UP:         nxt_st.rdata = st_ff.pull_up;
                OFS_RISE_ENABLE:     nxt_st.rdata = st_ff.rise_en;
                OFS_FALL_ENABLE:     nxt_st.rdata = st_ff.fall_en;
                OFS_SPECIAL_THRESH:  nxt_st.rdata[SPECIAL_BIT] = st_ff.sp_threshold;
                OFS_SPECIAL_PULL_UP: nxt_st.rdata[SPECIAL_BIT] = st_ff.sp_pull_up;
                OFS_SPECIAL_EDGE:
                begin
                    nxt_st.rdata[SP_RISE_BIT] = st_ff.sp_rise_en;
                    nxt_st.rdata[SP_FALL_BIT] = st_ff.sp_fall_en;
                end
                OFS_SPECIAL_PORT:    nxt_st.rdata[SPECIAL_BIT] = sp_present ? sp_level : 1'b1;
                default:             nxt_st.rdata = RST_ZERO;
            endcase
        end

        // Registered pin drive
        nxt_st.pin_out    = drv_val;
        nxt_st.pin_oe_n   = drv_oe_n;
        nxt_st.pull_up_on = st_ff.pull_up;
        nxt_st.slew_on    = st_ff.slew_limit;

        // pull-up forced for reset or programming
        nxt_st.sp_pull_up_on = (external_reset_pin_enable | low_voltage_prog_enable)
                               ? 1'b1 : st_ff.sp_pull_up;

        nxt_st.level_prev = level_dig;
        nxt_st.change_evt = (level_dig & ~st_ff.level_prev & st_ff.rise_en)
                          | (~level_dig & st_ff.level_prev & st_ff.fall_en);

        // special events only when port present
        nxt_st.sp_prev       = sp_level;
        nxt_st.sp_change_evt = sp_present
                             & ((sp_level & ~st_ff.sp_prev & st_ff.sp_rise_en)
                              | (~sp_level & st_ff.sp_prev & st_ff.sp_fall_en));
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            // analog mode after reset
            // Pins stay inputs until software enables drivers
            st_ff <= '{analog_select: RST_ANALOG_SELECT,
                       direction:     RST_DIRECTION,
                       pin_oe_n:      RST_DIRECTION,
                       output_latch:  RST_ZERO,
                       sp_pull_up_on: 1'b1,
                       default:       '0};
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign rdata                 = st_ff.rdata;
    assign pin_out               = st_ff.pin_out;
    assign pin_oe_n              = st_ff.pin_oe_n;
    assign pull_up_on            = st_ff.pull_up_on;
    assign slew_limit_on         = st_ff.slew_on;
    assign threshold_ttl         = st_ff.input_threshold;
    assign special_pin_pull_up   = st_ff.sp_pull_up_on;
    assign special_threshold_ttl = st_ff.sp_threshold;
    assign analog_in_en          = st_ff.analog_select;
    assign digital_in            = level_dig;
    assign special_digital_in    = sp_present & sp_level;
    assign change_evt            = st_ff.change_evt;
    assign special_change_evt    = st_ff.sp_change_evt;

endmodule : general_purpose_io_port

//--- dv/general_purpose_io_port_asserts.sv
// Purpose: Concurrent checks on the I/O port pins and register port
// Assumes: One clock, async active-high reset, drive outputs one cycle late
// Notes:   A few control registers are mirrored from the write strobe
`timescale 1ns/1ps

module general_purpose_io_port_asserts
    import gpio_pkg::*;
(
    // Clock and reset
    input wire logic        clk,
    input wire logic        reset,
    // Register port
    input wire logic [11:0] addr,
    input wire logic [7:0]  wdata,
    input wire logic        wr,
    input wire logic        rd,
    input wire logic [7:0]  rdata,
    // Pins and straps
    input wire logic [7:0]  pin_st,
    input wire logic [7:0]  pin_ttl,
    input wire logic [7:0]  pin_out,
    input wire logic [7:0]  pin_oe_n,
    input wire logic [7:0]  pull_up_on,
    input wire logic [7:0]  threshold_ttl,
    input wire logic        special_pin_pull_up,
    input wire logic        external_reset_pin_enable,
    input wire logic        low_voltage_prog_enable,
    input wire logic [7:0]  config_own,
    input wire logic [7:0]  config_oe,
    input wire logic [7:0]  analog_out_en,
    input wire logic [7:0]  analog_in_en,
    input wire logic [7:0]  i2c_own,
    input wire logic [7:0]  digital_in,
    input wire logic        special_digital_in,
    input wire logic [7:0]  change_evt,
    input wire logic        special_change_evt
);
    // ------------------------------------------------------------
    // Helper mirrors, aligned to the registered drive outputs
    // ------------------------------------------------------------
    logic [7:0] dir_ff, dir_d_ff, od_ff, od_d_ff, pu_ff, pu_d_ff;
    logic [7:0] own_ff, coe_ff, aout_ff, i2c_ff;
    logic [1:0] up_ff;

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            dir_ff   <= RST_DIRECTION;
            dir_d_ff <= RST_DIRECTION;
            od_ff    <= 8'h00;
            od_d_ff  <= 8'h00;
            pu_ff    <= 8'h00;
            pu_d_ff  <= 8'h00;
            own_ff   <= 8'h00;
            coe_ff   <= 8'h00;
            aout_ff  <= 8'h00;
            i2c_ff   <= 8'h00;
            up_ff    <= 2'd0;
        end
        else
        begin
            if (wr && addr == OFS_DIRECTION)
                dir_ff <= wdata;
            if (wr && addr == OFS_OPEN_DRAIN)
                od_ff <= wdata;
            if (wr && addr == OFS_PULL_UP)
                pu_ff <= wdata;
            dir_d_ff <= dir_ff;
            od_d_ff  <= od_ff;
            pu_d_ff  <= pu_ff;
            own_ff   <= config_own;
            coe_ff   <= config_oe;
            aout_ff  <= analog_out_en & ~config_own;
            i2c_ff   <= i2c_own;
            // Synchroniser history is only trusted once it has refilled
            if (up_ff != 2'd3)
                up_ff <= up_ff + 2'd1;
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (reset);

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    read_idle_zero_a: assert property (!$past(rd) |-> rdata == 8'h00)
        else $error("read data not zero outside a read");
    analog_read_zero_a: assert property ((digital_in & analog_in_en) == 8'h00)
        else $error("analog pin reads non-zero");
    thresh_read_a: assert property (up_ff == 2'd3 |-> digital_in ==
        (((threshold_ttl & $past(pin_ttl, 2)) | (~threshold_ttl & $past(pin_st, 2))) & ~analog_in_en))
        else $error("digital input not from selected threshold");
    edge_cause_a: assert property (up_ff == 2'd3 && change_evt != 8'h00 |->
        (change_evt & ~($past(digital_in) ^ $past(digital_in, 2))) == 8'h00)
        else $error("change event without a level change");
    aout_hiz_a: assert property ((pin_oe_n & aout_ff) == aout_ff)
        else $error("analog output pin still driven");
    config_first_a: assert property (((pin_oe_n ^ ~coe_ff) & own_ff) == 8'h00)
        else $error("config owned pin enable wrong");
    dir_input_a: assert property ((~pin_oe_n & dir_d_ff & ~own_ff) == 8'h00)
        else $error("input pin driven");
    od_no_high_a: assert property ((~pin_oe_n & pin_out & (od_d_ff | i2c_ff) & ~own_ff) == 8'h00)
        else $error("open-drain pin driven high");
    pull_up_copy_a: assert property (pull_up_on == pu_d_ff)
        else $error("pull-up enable differs from register");
    sp_pull_force_a: assert property (external_reset_pin_enable || low_voltage_prog_enable |=>
        special_pin_pull_up)
        else $error("special pull-up not forced");
    sp_absent_a: assert property (external_reset_pin_enable [*3] |->
        !special_digital_in && !special_change_evt)
        else $error("special pin active while reset pin enabled");

    // Main scenarios reached
    cover property (change_evt != 8'h00);
    cover property (special_change_evt);
    cover property (aout_ff != 8'h00);
    cover property ((od_d_ff | i2c_ff) != 8'h00 && pin_oe_n != 8'hff);

endmodule : general_purpose_io_port_asserts

bind general_purpose_io_port general_purpose_io_port_asserts u_chk (.*);

//--- dv/general_purpose_io_port_tb_top.sv
// Purpose: Self-checking bench for the general purpose I/O port
// Assumes: Pins are driven by the bench directly, no loopback
// Notes:   Register accesses are one-cycle strobes, read data one cycle late
`timescale 1ns/1ps

module general_purpose_io_port_tb_top;
    import gpio_pkg::*;

    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic        clk, reset, wr, rd, special_pin_st, special_pin_ttl;
    logic        external_reset_pin_enable, low_voltage_prog_enable;
    logic        special_pin_pull_up, special_threshold_ttl, special_digital_in, special_change_evt;
    logic [11:0] addr;
    logic [7:0]  wdata, rdata, pin_st, pin_ttl, pin_out, pin_oe_n, pull_up_on, slew_limit_on;
    logic [7:0]  threshold_ttl, config_own, config_out, config_oe, analog_out_en, analog_in_en;
    logic [7:0]  remap_out_sel, remap_out, i2c_own, digital_in, change_evt;
    int          bad_count = 0;
    int          num_checks = 0;
    logic [11:0] rst_addr [11] = '{OFS_DIRECTION, OFS_ANALOG_SELECT, OFS_OUTPUT_LATCH, OFS_INPUT_THRESHOLD,
        OFS_SLEW_LIMIT, OFS_OPEN_DRAIN, OFS_PULL_UP, OFS_RISE_ENABLE, OFS_PIN_LEVEL, OFS_SPECIAL_PORT, 12'h000};
    logic [7:0]  rst_val [11] = '{8'hff, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h08, 8'h00};
    logic [7:0]  ev_pin [5] = '{8'h5b, 8'h58, 8'h5c, 8'h54, 8'h44};
    logic [7:0]  ev_exp [5] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h00};

    general_purpose_io_port DUT (.*);

    always #4 clk = ~clk;

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : cyc

    task automatic wr_reg(input logic [11:0] a, input logic [7:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
    endtask : wr_reg

    // Read data stands only in the cycle after the strobe
    task automatic rd_chk(input logic [11:0] a, input logic [7:0] e);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        #1;
        check(rdata, e);
    endtask : rd_chk

    task automatic ev_watch(input logic [7:0] st, input logic sp, input logic [7:0] e, input logic se);
        logic [7:0] acc;
        logic       sacc;
        acc  = 8'h00;
        sacc = 1'b0;
        @(posedge clk);
        pin_st         <= st;
        special_pin_st <= sp;
        repeat (6)
        begin
            @(posedge clk);
            #1;
            acc  = acc | change_evt;
            sacc = sacc | special_change_evt;
        end
        check(acc, e);
        check({7'h00, sacc}, {7'h00, se});
    endtask : ev_watch

    task automatic print_verdict();
        if (bad_count == 0 && num_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : print_verdict

    // ------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------
    initial
    begin
        clk   = 1'b0;
        reset = 1'b1;
        {addr, wdata, wr, rd, pin_st, pin_ttl, special_pin_st, special_pin_ttl} = '0;
        {config_own, config_out, config_oe, analog_out_en, remap_out_sel, remap_out, i2c_own} = '0;
        external_reset_pin_enable = 1'b1;
        low_voltage_prog_enable   = 1'b0;
        repeat (4) @(posedge clk);
        reset <= 1'b0;
        cyc(1);
        check(pin_oe_n, 8'hff);
        check(analog_in_en, 8'hff);
        check({7'h00, special_pin_pull_up}, 8'h01);
        for (int i = 0; i < 11; i++)
            rd_chk(rst_addr[i], rst_val[i]);
        wr_reg(OFS_ANALOG_SELECT, 8'h00);
        wr_reg(OFS_DIRECTION, 8'h00);
        wr_reg(OFS_OUTPUT_LATCH, 8'ha5);
        cyc(1);
        check(pin_out, 8'ha5);
        check(pin_oe_n, 8'h00);
        rd_chk(OFS_OUTPUT_LATCH, 8'ha5);
        rd_chk(OFS_PIN_LEVEL, 8'h00);
        wr_reg(OFS_PIN_LEVEL, 8'h3c);
        rd_chk(OFS_OUTPUT_LATCH, 8'h3c);
        wr_reg(OFS_OUTPUT_LATCH, 8'hc3);
        wr_reg(OFS_PIN_LEVEL, 8'h81);
        rd_chk(OFS_OUTPUT_LATCH, 8'h81);
        @(posedge clk);
        pin_st  <= 8'h5a;
        pin_ttl <= 8'ha5;
        cyc(3);
        rd_chk(OFS_PIN_LEVEL, 8'h5a);
        wr_reg(OFS_INPUT_THRESHOLD, 8'hff);
        cyc(0);
        check(threshold_ttl, 8'hff);
        rd_chk(OFS_PIN_LEVEL, 8'ha5);
        wr_reg(OFS_INPUT_THRESHOLD, 8'h00);
        wr_reg(OFS_ANALOG_SELECT, 8'h0f);
        cyc(1);
        rd_chk(OFS_PIN_LEVEL, 8'h50);
        check(analog_in_en, 8'h0f);
        check(digital_in, 8'h50);
        check(pin_oe_n, 8'h00);
        check(pin_out, 8'h81);
        wr_reg(OFS_ANALOG_SELECT, 8'h00);
        wr_reg(OFS_OPEN_DRAIN, 8'hff);
        cyc(1);
        check(pin_oe_n, 8'h81);
        wr_reg(OFS_OPEN_DRAIN, 8'h00);
        remap_out_sel <= 8'h0f;
        remap_out     <= 8'h0f;
        i2c_own       <= 8'h0f;
        cyc(2);
        check(pin_oe_n, 8'h0f);
        check(pin_out & 8'hf0, 8'h80);
        @(posedge clk);
        remap_out <= 8'h05;
        cyc(2);
        check(pin_oe_n, 8'h05);
        @(posedge clk);
        {remap_out_sel, i2c_own} <= '0;
        analog_out_en <= 8'h03;
        config_own    <= 8'h01;
        config_oe     <= 8'h01;
        config_out    <= 8'h01;
        cyc(2);
        check(pin_oe_n, 8'h02);
        check(pin_out & 8'h01, 8'h01);
        @(posedge clk);
        {analog_out_en, config_own} <= '0;
        wr_reg(OFS_DIRECTION, 8'haa);
        cyc(1);
        check(pin_oe_n, 8'haa);
        wr_reg(OFS_SLEW_LIMIT, 8'h96);
        wr_reg(OFS_PULL_UP, 8'h69);
        cyc(1);
        check(slew_limit_on, 8'h96);
        check(pull_up_on, 8'h69);
        wr_reg(OFS_RISE_ENABLE, 8'h05);
        wr_reg(OFS_FALL_ENABLE, 8'h0a);
        for (int i = 0; i < 5; i++)
            ev_watch(ev_pin[i], 1'b0, ev_exp[i], 1'b0);
        @(posedge clk);
        external_reset_pin_enable <= 1'b0;
        wr_reg(OFS_SPECIAL_PULL_UP, 8'h00);
        cyc(1);
        check({7'h00, special_pin_pull_up}, 8'h00);
        rd_chk(OFS_SPECIAL_PORT, 8'h00);
        wr_reg(OFS_SPECIAL_EDGE, 8'h01);
        ev_watch(8'h44, 1'b1, 8'h00, 1'b1);
        rd_chk(OFS_SPECIAL_PORT, 8'h08);
        wr_reg(OFS_SPECIAL_PORT, 8'h00);
        rd_chk(OFS_SPECIAL_PORT, 8'h08);
        check({7'h00, special_digital_in}, 8'h01);
        wr_reg(OFS_SPECIAL_THRESH, 8'h08);
        cyc(0);
        check({7'h00, special_threshold_ttl}, 8'h01);
        rd_chk(OFS_SPECIAL_PORT, 8'h00);
        @(posedge clk);
        low_voltage_prog_enable <= 1'b1;
        cyc(2);
        check({7'h00, special_pin_pull_up}, 8'h01);
        @(posedge clk);
        low_voltage_prog_enable <= 1'b0;
        wr_reg(OFS_SPECIAL_PULL_UP, 8'h08);
        cyc(1);
        check({7'h00, special_pin_pull_up}, 8'h01);
        print_verdict();
    end

    // Whole sequence needs well under a thousand cycles
    initial
    begin
        repeat (20000) @(posedge clk);
        bad_count++;
        print_verdict();
    end

endmodule : general_purpose_io_port_tb_top
